/* File: tpo_fifo.sv */
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock; synchronous active-low reset.
// Notes: Full and empty are exact; a push into a full FIFO is refused.
`timescale 1ns/1ns
`default_nettype none

module tpo_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import tpo_pkg::*;

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [CNT_W-1:0] count;
  } tpo_fifo_state_t;

  tpo_fifo_state_t r;
  tpo_fifo_state_t next_r;
  logic push;
  logic pop;

  assign in_ready = (r.count != CNT_FULL);
  assign out_valid = (r.count != '0);
  assign out_data = r.mem[r.rptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wptr] = in_data;
      next_r.wptr = (r.wptr == PTR_LAST) ? '0 : r.wptr + 1'b1;
    end
    if (pop) begin
      next_r.rptr = (r.rptr == PTR_LAST) ? '0 : r.rptr + 1'b1;
    end
    if (push && !pop) begin
      next_r.count = r.count + 1'b1;
    end else if (pop && !push) begin
      next_r.count = r.count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

`default_nettype wire

/* File: tpo_insert_port.sv */
// Purpose: Transmit path overhead insertion, path alarm forcing and bus parity.
// Assumes: clk far faster than the reference clock tck, which is sampled as a pin.
// Notes: Upstream framer words pass a 4-word FIFO; one word leaves per tck rise.
//
// Behaviour
// - Parity always covers all eight transmit data bits.
// - Config bits add payload-active and composite timing, and pick odd or even.
// - Parity updates on each reference clock rise, aligned with its data.
// - Path alarm high forces all-ones over payload envelope and pointer bytes.
// - Alarm also forced by config bit or incoming failure code in tandem mode.
// - Single-stream modes honour only index 1 of alarm, data and enable.
// - Path alarm inputs are sampled on the reference clock rise.
// - Enable high inserts the serial overhead bit into J1, C2, G1, F2 and Z3 to Z5 bits.
// - Enable low fills those bits from internally held values.
// - Enable high during B3 bits arms an error mask.
// - Armed mask inverts the B3 bit when serial input is high.
// - Serial input also masks errors into the H4 byte.
// - Serial data and enable are sampled on the stream's overhead clock rise.
// - Concatenated mode runs overhead clock 1 at one 32nd of the reference clock, clocks 2 and 3 idle.
// - Frame marker is high while bit 1 of J1 is on the serial stream.
// - Frame marker changes on the overhead clock fall.
// - Single-stream modes toggle only frame marker 1.
// - Overhead clocks change on the reference clock fall.
`timescale 1ns/1ns
`default_nettype none

module tpo_insert_port (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic [7:0] in_byte,
  input wire logic in_payload_active,
  input wire logic in_composite,
  input wire tpo_pkg::tpo_sel_t in_sel,
  input wire logic [1:0] in_stream,
  input wire logic in_valid,
  output logic in_ready,
  input wire tpo_pkg::tpo_mode_t mode,
  input wire logic parity_cover_pa,
  input wire logic parity_cover_comp,
  input wire logic parity_odd,
  input wire logic alarm_force_cfg,
  input wire logic tcte_mode,
  input wire logic [2:0] isf_detect,
  input wire logic [8:0][7:0] ovh_fixed_value,
  input wire logic [2:0] tx_alarm_force,
  input wire logic [2:0] ovh_serial_in,
  input wire logic [2:0] ovh_insert_enable,
  output logic [2:0] ovh_port_clock,
  output logic [2:0] ovh_frame_marker,
  output logic [7:0] tx_byte_bus,
  output logic tx_payload_active,
  output logic tx_composite_timing,
  output logic tx_bus_parity
);
  import tpo_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic tck_s1;
    logic tck_s2;
    logic tck_d;
    logic [2:0] alarm_s1;
    logic [2:0] alarm_s2;
    logic [2:0] alarm_q;
    logic [2:0] ovh_d_s1;
    logic [2:0] ovh_d_s2;
    logic [2:0] ovh_e_s1;
    logic [2:0] ovh_e_s2;
    logic [TPO_HALF_W-1:0] half_cnt;
    logic ovh_clk;
    logic [TPO_BIT_IDX_W-1:0] bit_idx;
    logic marker;
    logic [TPO_STREAMS-1:0][TPO_POH_BYTES-1:0][7:0] ovh_data;
    logic [TPO_STREAMS-1:0][TPO_POH_BYTES-1:0][7:0] ovh_en;
    logic [7:0] out_byte;
    logic out_pa;
    logic out_comp;
    logic out_par;
  } tpo_state_t;

  tpo_state_t r;
  tpo_state_t next_r;

  logic single;
  logic tck_rise;
  logic tck_fall;
  tpo_word_t fifo_in;
  tpo_word_t word;
  logic word_valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Input FIFO; the word is drained on each reference clock rise
  assign fifo_in.sel = in_sel;
  assign fifo_in.stream = in_stream;
  assign fifo_in.composite = in_composite;
  assign fifo_in.payload_active = in_payload_active;
  assign fifo_in.data = in_byte;

  tpo_fifo #(
    .WIDTH(TPO_WORD_W),
    .DEPTH(TPO_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_data(fifo_in),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(word),
    .out_valid(word_valid),
    .out_ready(tck_rise)
  );

  assign single = (mode != TPO_MODE_3XSTS1);
  assign tck_rise = r.tck_s2 & ~r.tck_d;
  assign tck_fall = ~r.tck_s2 & r.tck_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [1:0] s;
    logic [3:0] k;
    logic [3:0] wb;
    logic [2:0] wp;
    logic ais;
    logic [7:0] ovd;
    logic [7:0] ove;
    logic [7:0] b;
    logic [TPO_BIT_IDX_W-1:0] idx;
    s = '0;
    k = '0;
    wb = '0;
    wp = '0;
    ais = 1'b0;
    ovd = '0;
    ove = '0;
    b = '0;
    idx = '0;
    next_r = r;

    // Pin synchronisers
    next_r.tck_s1 = tck;
    next_r.tck_s2 = r.tck_s1;
    next_r.tck_d = r.tck_s2;
    next_r.alarm_s1 = tx_alarm_force;
    next_r.alarm_s2 = r.alarm_s1;
    next_r.ovh_d_s1 = ovh_serial_in;
    next_r.ovh_d_s2 = r.ovh_d_s1;
    next_r.ovh_e_s1 = ovh_insert_enable;
    next_r.ovh_e_s2 = r.ovh_e_s1;

    // Overhead clock divider on reference clock falls
    if (tck_fall) begin
      if (r.half_cnt == TPO_HALF_LAST) begin
        next_r.half_cnt = '0;
        next_r.ovh_clk = ~r.ovh_clk;
        if (r.ovh_clk) begin
          // Falling overhead clock: step to next bit, move the marker
          idx = (r.bit_idx == TPO_BIT_IDX_LAST) ? TPO_BIT_IDX_FIRST : r.bit_idx + 1'b1;
          next_r.bit_idx = idx;
          next_r.marker = (idx == TPO_BIT_IDX_FIRST);
        end else begin
          // Rising overhead clock: capture data and enable of the current bit
          wb = r.bit_idx[6:3];
          wp = TPO_MSB_POS - r.bit_idx[2:0];
          for (int i = 0; i < TPO_STREAMS; i++) begin
            next_r.ovh_data[i][wb][wp] = r.ovh_d_s2[i];
            next_r.ovh_en[i][wb][wp] = r.ovh_e_s2[i];
          end
        end
      end else begin
        next_r.half_cnt = r.half_cnt + 1'b1;
      end
    end

    // Output word on reference clock rise
    if (tck_rise) begin
      next_r.alarm_q = r.alarm_s2;
      if (word_valid) begin
        s = single ? 2'h0 : word.stream;
        ais = r.alarm_q[s] | alarm_force_cfg | (tcte_mode & isf_detect[s]);
        k = 4'(word.sel) - 4'(TPO_SEL_J1);
        ovd = r.ovh_data[s][k];
        ove = r.ovh_en[s][k];
        unique case (word.sel)
          TPO_SEL_NONE: b = word.data;
          TPO_SEL_PTR, TPO_SEL_SPE: b = ais ? TPO_ALL_ONES : word.data;
          TPO_SEL_B3: b = ais ? TPO_ALL_ONES : word.data ^ (ove & ovd);
          TPO_SEL_H4: b = ais ? TPO_ALL_ONES : word.data ^ (ove & ovd);
          default: b = ais ? TPO_ALL_ONES
                           : (ove & ovd) | (~ove & ovh_fixed_value[k]);
        endcase
        next_r.out_byte = b;
        next_r.out_pa = word.payload_active;
        next_r.out_comp = word.composite;
        next_r.out_par = (^b) ^ (parity_cover_pa & word.payload_active)
                         ^ (parity_cover_comp & word.composite) ^ parity_odd;
      end else begin
        next_r.out_byte = '0;
        next_r.out_pa = 1'b0;
        next_r.out_comp = 1'b0;
        next_r.out_par = parity_odd;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign ovh_port_clock = single ? {2'b00, r.ovh_clk} : {3{r.ovh_clk}};
  assign ovh_frame_marker = single ? {2'b00, r.marker} : {3{r.marker}};
  assign tx_byte_bus = r.out_byte;
  assign tx_payload_active = r.out_pa;
  assign tx_composite_timing = r.out_comp;
  assign tx_bus_parity = r.out_par;

endmodule

`default_nettype wire

/* File: tpo_insert_port_properties.sv */
// Purpose: Port checks of the overhead insert port
// Assumes: tck period is exactly eight clk periods
// Notes: Bound to every tpo_insert_port instance
`timescale 1ns/1ns
`default_nettype none
module tpo_insert_port_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic in_ready,
  input wire tpo_pkg::tpo_mode_t mode,
  input wire logic parity_cover_pa,
  input wire logic parity_cover_comp,
  input wire logic parity_odd,
  input wire logic alarm_force_cfg,
  input wire logic [2:0] ovh_port_clock,
  input wire logic [2:0] ovh_frame_marker,
  input wire logic [7:0] tx_byte_bus,
  input wire logic tx_payload_active,
  input wire logic tx_composite_timing,
  input wire logic tx_bus_parity
);
  import tpo_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic ck;
  logic mk;
  assign ck = ovh_port_clock[0];
  assign mk = ovh_frame_marker[0];
  ////////////////////////////////////////////////////////////////////////////////
  property p_parity;
    $changed({tx_byte_bus, tx_payload_active, tx_composite_timing, tx_bus_parity}) |->
      tx_bus_parity == (^tx_byte_bus ^ (parity_cover_pa & tx_payload_active)
      ^ (parity_cover_comp & tx_composite_timing) ^ parity_odd);
  endproperty
  a_parity: assert property (p_parity) else $error("bad parity");
  property p_tx_edge;
    $changed(tx_byte_bus) |-> $past(tck, 2) && !$past(tck, 6);
  endproperty
  a_tx_edge: assert property (p_tx_edge) else $error("bus off tck rise");
  property p_ck_edge;
    $changed(ck) |-> !$past(tck, 2) && $past(tck, 6);
  endproperty
  a_ck_edge: assert property (p_ck_edge) else $error("ovh clock off tck fall");
  property p_ck_half;
    $changed(ck) |-> ##128 $changed(ck);
  endproperty
  a_ck_half: assert property (p_ck_half) else $error("ovh clock rate");
  property p_ck_min;
    $changed(ck) |=> $stable(ck)[*8];
  endproperty
  a_ck_min: assert property (p_ck_min) else $error("ovh clock glitch");
  property p_mk_len;
    $rose(mk) |-> ##256 $fell(mk);
  endproperty
  a_mk_len: assert property (p_mk_len) else $error("marker width");
  property p_mk_edge;
    $changed(mk) |-> !ck && ($past(ck) || $past(ck, 2));
  endproperty
  a_mk_edge: assert property (p_mk_edge) else $error("marker off clock fall");
  property p_single;
    (mode != TPO_MODE_3XSTS1)[*2] |->
      ovh_port_clock[2:1] == 2'h0 && ovh_frame_marker[2:1] == 2'h0;
  endproperty
  a_single: assert property (p_single) else $error("idle streams active");
  c_mark: cover property ($rose(mk));
  c_full: cover property (!in_ready);
  c_alarm: cover property (alarm_force_cfg && $changed(tx_byte_bus));
endmodule
bind tpo_insert_port tpo_insert_port_properties u_props (
  .clk(clk), .resetn(resetn), .tck(tck), .in_ready(in_ready), .mode(mode),
  .parity_cover_pa(parity_cover_pa), .parity_cover_comp(parity_cover_comp),
  .parity_odd(parity_odd), .alarm_force_cfg(alarm_force_cfg),
  .ovh_port_clock(ovh_port_clock), .ovh_frame_marker(ovh_frame_marker),
  .tx_byte_bus(tx_byte_bus), .tx_payload_active(tx_payload_active),
  .tx_composite_timing(tx_composite_timing), .tx_bus_parity(tx_bus_parity)
);
`default_nettype wire

/* File: tpo_insert_port_tb.sv */
// Purpose: Self-checking bench of the overhead insert port
// Assumes: Source model repeats one overhead frame
// Notes: Words are pushed four at a time after a tck fall
`timescale 1ns/1ns
`default_nettype none
module tpo_insert_port_tb;
  import tpo_pkg::*;
  localparam logic [71:0] SER = 72'h5ac396e13c0fa578d2;
  localparam logic [71:0] ENP = 72'hff0ff000ff3cc3aa55;
  localparam logic [8:0][7:0] FIX = 72'h192837465564738291;
  logic clk = 0, resetn = 0, tck = 0, in_valid = 0, in_ready;
  logic pcp = 0, pcc = 0, podd = 0, afc = 0, tcte = 0;
  logic [2:0] isf = 0, alarm = 0, ser, en, ock, mark;
  logic [7:0] txb;
  logic txpa, txc, txp;
  tpo_word_t inw = '0;
  tpo_mode_t mode = TPO_MODE_3XSTS1;
  int miscompares = 0, num_checks = 0;
  initial forever #4 clk = ~clk;
  initial begin
    #3;
    forever #32 tck = ~tck;
  end
  tpo_insert_port u_dut (.clk(clk), .resetn(resetn), .tck(tck), .in_byte(inw.data),
    .in_payload_active(inw.payload_active), .in_composite(inw.composite), .in_sel(inw.sel),
    .in_stream(inw.stream), .in_valid(in_valid), .in_ready(in_ready), .mode(mode),
    .parity_cover_pa(pcp), .parity_cover_comp(pcc), .parity_odd(podd),
    .alarm_force_cfg(afc), .tcte_mode(tcte), .isf_detect(isf), .ovh_fixed_value(FIX),
    .tx_alarm_force(alarm), .ovh_serial_in(ser), .ovh_insert_enable(en),
    .ovh_port_clock(ock), .ovh_frame_marker(mark), .tx_byte_bus(txb),
    .tx_payload_active(txpa), .tx_composite_timing(txc), .tx_bus_parity(txp));
  tpo_ovh_source u_src (.clk(clk), .resetn(resetn), .ovh_port_clock(ock),
    .ovh_frame_marker(mark), .ser_pat(SER), .en_pat(ENP), .ovh_serial_in(ser),
    .ovh_insert_enable(en));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  function automatic tpo_word_t wd(tpo_sel_t s, logic [1:0] st, logic [7:0] d);
    return '{s, st, d[1], d[0], d};
  endfunction
  function automatic logic [7:0] expb(tpo_word_t w, logic ais);
    int b;
    logic [7:0] s, e;
    b = int'(w.sel) - 1;
    s = SER[71 - 8 * b -: 8];
    e = ENP[71 - 8 * b -: 8];
    if (ais) return 8'hff;
    case (w.sel)
      TPO_SEL_NONE, TPO_SEL_PTR, TPO_SEL_SPE: return w.data;
      TPO_SEL_B3, TPO_SEL_H4: return w.data ^ (e & s);
      default: return (e & s) | (~e & FIX[b]);
    endcase
  endfunction
  // Four back-to-back pushes, refusal when full, then one word per tck
  task automatic burst(input tpo_word_t w [4], input logic [3:0] ais);
    logic [7:0] e;
    repeat (16) @(negedge clk);
    @(negedge tck);
    @(negedge clk);
    in_valid = 1;
    for (int i = 0; i < 4; i++) begin
      inw = w[i];
      @(negedge clk);
    end
    in_valid = 0;
    cmp1(in_ready, 1'b0);
    for (int i = 0; i < 5; i++) begin
      repeat (i == 0 ? 5 : 8) @(negedge clk);
      e = (i < 4) ? expb(w[i], ais[i]) : 8'h00;
      cmp8(txb, e);
      if (i < 4) cmp8({6'h00, txpa, txc}, {6'h00, w[i].payload_active, w[i].composite});
      if (i < 4) cmp1(txp, ^e ^ (pcp & w[i].payload_active)
        ^ (pcc & w[i].composite) ^ podd);
      else cmp1(txp, podd);
    end
  endtask
  initial begin
    #600000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (6) @(negedge clk);
    resetn = 1;
    cmp1(in_ready, 1'b1);
    @(posedge mark[0]);
    @(posedge mark[0]);
    pcp = 1;
    pcc = 1;
    burst('{wd(TPO_SEL_J1, 2'h0, 8'h3c), wd(TPO_SEL_B3, 2'h0, 8'ha5),
      wd(TPO_SEL_H4, 2'h1, 8'h0f), wd(TPO_SEL_Z5, 2'h2, 8'he2)}, 4'h0);
    pcp = 0;
    podd = 1;
    burst('{wd(TPO_SEL_C2, 2'h0, 8'h11), wd(TPO_SEL_G1, 2'h1, 8'h22),
      wd(TPO_SEL_F2, 2'h2, 8'h47), wd(TPO_SEL_Z3, 2'h0, 8'h81)}, 4'h0);
    pcp = 1;
    pcc = 0;
    alarm = 3'h2;
    burst('{wd(TPO_SEL_Z4, 2'h2, 8'h96), wd(TPO_SEL_NONE, 2'h1, 8'h5d),
      wd(TPO_SEL_PTR, 2'h1, 8'h12), wd(TPO_SEL_SPE, 2'h0, 8'h34)}, 4'h4);
    alarm = 3'h0;
    afc = 1;
    burst('{wd(TPO_SEL_SPE, 2'h1, 8'h77), wd(TPO_SEL_PTR, 2'h2, 8'h88),
      wd(TPO_SEL_SPE, 2'h0, 8'h99), wd(TPO_SEL_PTR, 2'h1, 8'haa)}, 4'hf);
    afc = 0;
    tcte = 1;
    isf = 3'h4;
    burst('{wd(TPO_SEL_SPE, 2'h2, 8'h61), wd(TPO_SEL_SPE, 2'h1, 8'h62),
      wd(TPO_SEL_PTR, 2'h2, 8'h63), wd(TPO_SEL_PTR, 2'h0, 8'h64)}, 4'h5);
    tcte = 0;
    mode = TPO_MODE_STS1;
    alarm = 3'h6;
    burst('{wd(TPO_SEL_SPE, 2'h0, 8'h71), wd(TPO_SEL_SPE, 2'h1, 8'h72),
      wd(TPO_SEL_J1, 2'h1, 8'h73), wd(TPO_SEL_PTR, 2'h2, 8'h74)}, 4'h0);
    mode = TPO_MODE_STS3C;
    alarm = 3'h1;
    burst('{wd(TPO_SEL_SPE, 2'h1, 8'h81), wd(TPO_SEL_PTR, 2'h2, 8'h82),
      wd(TPO_SEL_B3, 2'h0, 8'h83), wd(TPO_SEL_PTR, 2'h0, 8'h84)}, 4'hf);
    repeat (600) @(negedge clk);
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: tpo_ovh_source.sv */
// Purpose: External serial overhead source model
// Assumes: Patterns are sent most significant bit first
// Notes: Bit index follows the frame marker
`timescale 1ns/1ns
`default_nettype none
module tpo_ovh_source (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] ovh_port_clock,
  input wire logic [2:0] ovh_frame_marker,
  input wire logic [71:0] ser_pat,
  input wire logic [71:0] en_pat,
  output logic [2:0] ovh_serial_in,
  output logic [2:0] ovh_insert_enable
);
  logic [2:0] ck_q;
  logic [2:0] fell_q;
  logic [2:0][6:0] idx;
  always_ff @(posedge clk) begin
    logic [6:0] n;
    ck_q <= ovh_port_clock;
    fell_q <= ck_q & ~ovh_port_clock;
    for (int s = 0; s < 3; s++) begin
      n = ovh_frame_marker[s] ? 7'h00 : idx[s] + 7'h01;
      if (!resetn) begin
        idx[s] <= 7'h00;
        ovh_serial_in[s] <= 1'b0;
        ovh_insert_enable[s] <= 1'b0;
      end else if (fell_q[s]) begin
        idx[s] <= n;
        ovh_serial_in[s] <= ser_pat[7'h47 - n];
        ovh_insert_enable[s] <= en_pat[7'h47 - n];
      end
    end
  end
endmodule
`default_nettype wire

/* File: tpo_pkg.sv */
// Purpose: Shared constants and types of the transmit path overhead insert port.
// Assumes: Imported whole by every design file of the block.
// Notes: Stream index 1 of the pins maps to bit 0 of every three-bit port.
package tpo_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int TPO_CLK_KHZ = 125000;
  localparam int TPO_TCK_KHZ = 19440;
  localparam int TPO_OVH_CLK_KHZ = 576;
  // Reference clock edges per half period of the overhead clock, rounded down
  localparam int TPO_OVH_HALF = TPO_TCK_KHZ / (2 * TPO_OVH_CLK_KHZ);
  localparam int TPO_HALF_W = 5;
  localparam logic [TPO_HALF_W-1:0] TPO_HALF_LAST = TPO_HALF_W'(TPO_OVH_HALF - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Serial overhead frame: nine bytes of eight bits, most significant first
  localparam int TPO_STREAMS = 3;
  localparam int TPO_POH_BYTES = 9;
  localparam int TPO_BIT_IDX_W = 7;
  localparam logic [TPO_BIT_IDX_W-1:0] TPO_BIT_IDX_LAST = 7'h47;
  localparam logic [TPO_BIT_IDX_W-1:0] TPO_BIT_IDX_FIRST = 7'h00;
  localparam logic [2:0] TPO_MSB_POS = 3'h7;
  localparam logic [7:0] TPO_ALL_ONES = 8'hff;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte position of each transmit word
  typedef enum logic [3:0] {
    TPO_SEL_NONE,
    TPO_SEL_J1,
    TPO_SEL_B3,
    TPO_SEL_C2,
    TPO_SEL_G1,
    TPO_SEL_F2,
    TPO_SEL_H4,
    TPO_SEL_Z3,
    TPO_SEL_Z4,
    TPO_SEL_Z5,
    TPO_SEL_PTR,
    TPO_SEL_SPE
  } tpo_sel_t;

  typedef enum logic [1:0] {
    TPO_MODE_3XSTS1,
    TPO_MODE_STS3C,
    TPO_MODE_STS1
  } tpo_mode_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Word held in the input FIFO
  localparam int TPO_FIFO_DEPTH = 4;
  typedef struct packed {
    tpo_sel_t sel;
    logic [1:0] stream;
    logic composite;
    logic payload_active;
    logic [7:0] data;
  } tpo_word_t;
  localparam int TPO_WORD_W = $bits(tpo_word_t);

endpackage
